// *** src/sacp_pkg.sv ***
// Shared constants, carrier types and decode helpers for the serial converter control port.
// Assumes one system clock domain and one host transfer-clock domain.
`default_nettype none

package sacp_pkg;

  // Result and address widths
  localparam int          RES_W          = 8;
  localparam int          ADDR_W         = 4;

  // Transfer framing, counted in transfer-clock edges within a frame of eight
  localparam logic [2:0]  ADDR_EDGES     = 3'h4;   // Rising edges that carry address bits
  localparam logic [2:0]  SAMPLE_FALL    = 3'h3;   // Falling edge count at which sampling opens
  localparam logic [2:0]  EDGE_LAST      = 3'h7;   // Count seen at the 8th falling edge
  localparam logic [2:0]  MSB_IDX        = 3'h7;

  // Conversion timing in system clock cycles
  localparam logic [5:0]  CONV_LAST      = 6'h23;  // 36 cycles, numbered 0 to 35
  localparam logic [5:0]  SAR_DEC_END    = 6'h20;  // Bit decisions take the first 32 cycles
  localparam logic [1:0]  SAR_STEP_LAST  = 2'h3;   // One decision per four cycles
  localparam logic [1:0]  CS_FILT_LAST   = 2'h2;   // Select filter spans three cycles
  localparam logic [RES_W-1:0] SAR_FIRST = 8'h80;

  // Channel map: eleven external inputs, then the self-test voltage
  localparam logic [3:0]  CH_LAST_EXT    = 4'hA;
  localparam logic [3:0]  CH_SELFTEST    = 4'hB;

  // Converter core state
  typedef struct packed {
    logic             comp_s1;
    logic             comp_s2;
    logic             busy;
    logic             done;
    logic [5:0]       cnt;
    logic [RES_W-1:0] mask;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;
  } sacp_sar_t;

  // What the core hands back to the control logic
  typedef struct packed {
    logic             busy;
    logic             done;
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] result;
  } sacp_sar_out_t;

  // System clock side of the control logic
  typedef struct packed {
    logic        cs_s1;
    logic        cs_s2;
    logic        st_s1;
    logic        st_s2;
    logic        st_s3;
    logic        smp_s1;
    logic        smp_s2;
    logic        smp_s3;
    logic [1:0]  filt;
    logic        active;
    logic        sample;
    logic [3:0]  mux_sel;
  } sacp_sys_t;

  // Unused codes fall onto the self-test input
  function automatic logic [3:0] sacp_chan_decode(input logic [3:0] a);
    return (a > CH_LAST_EXT) ? CH_SELFTEST : a;
  endfunction

endpackage

`default_nettype wire

// *** src/sacp_sar.sv ***
// Successive-approximation sequencer for the 8-bit converter.
// Assumes an external comparator reports input >= trial code on comp_i, asynchronously.
`default_nettype none

module sacp_sar
  import sacp_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic          comp_i,
  output var  sacp_sar_out_t st_o
);

  sacp_sar_t r;
  sacp_sar_t nxt;

  // Next state: one bit decided every four cycles, then settle to 36
  always_comb
  begin
    nxt         = r;
    nxt.comp_s1 = comp_i;
    nxt.comp_s2 = r.comp_s1;
    nxt.done    = 1'b0;
    if (!r.busy)
    begin
      if (start_i)
      begin
        nxt.busy  = 1'b1;
        nxt.cnt   = '0;
        nxt.sar   = '0;
        nxt.mask  = SAR_FIRST;
        nxt.trial = SAR_FIRST;
      end
    end
    else
    begin
      nxt.cnt = r.cnt + 6'h01;
      // Comparator gets two cycles to settle on each trial before the two-flop synchroniser
      if (r.cnt < SAR_DEC_END && r.cnt[1:0] == SAR_STEP_LAST)
      begin
        nxt.sar   = r.comp_s2 ? r.trial : r.sar;
        nxt.mask  = r.mask >> 1;
        nxt.trial = (r.comp_s2 ? r.trial : r.sar) | (r.mask >> 1);
      end
      if (r.cnt == CONV_LAST)
      begin
        nxt.busy   = 1'b0;
        nxt.done   = 1'b1;
        nxt.result = r.sar;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      r <= '0;
    else
      r <= nxt;
  end

  assign st_o = '{busy: r.busy, done: r.done, trial: r.trial, result: r.result};

  // Conversion lasts exactly 36 cycles from acceptance
  property p_conv_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(r.busy) |-> (r.busy)[*8] ##28 r.busy ##1 (!r.busy && r.done);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length not 36 cycles");

  // All eight bits have been decided when the result is taken
  property p_all_bits;
    @(posedge clk_i) disable iff (!rst_n_i)
    r.done |-> (r.mask == '0) && (r.result == $past(r.sar));
  endproperty
  a_all_bits: assert property (p_all_bits) else $error("result taken before all bits decided");

  c_conv_done: cover property (@(posedge clk_i) disable iff (!rst_n_i) r.done);

endmodule

`default_nettype wire

// *** src/sacp_top.sv ***
// Control logic of an 8-bit serial converter with a 12-way input selector.
// Assumes: MCLK_I is the conversion clock; IO_CLK_I comes from the host and may stop outside frames;
// an analog comparator, hold switch and selector sit outside and follow the outputs here.
// The link logic runs on both edges of IO_CLK_I; its edge counts and sampling request are cleared by select. Only a toggle,
// a level and the address cross to MCLK_I and the result crosses back, so a transfer clock that stops is harmless.
`default_nettype none

module sacp_top
  import sacp_pkg::*;
(
  input  wire logic             MCLK_I,
  input  wire logic             RST_N_I,
  input  wire logic             IO_CLK_I,
  input  wire logic             CS_N_I,
  input  wire logic             ADDR_I,
  input  wire logic             COMP_I,
  output logic                  DOUT_O,
  output logic                  DOUT_OE_O,
  output logic                  SAMPLE_O,
  output logic [ADDR_W-1:0]     MUX_SEL_O,
  output logic [RES_W-1:0]      DAC_O,
  output logic                  BUSY_O
);

  // Link edge counts and sampling request are held clear whenever select is high or the chip is reset
  logic            link_rst_n;
  assign link_rst_n = RST_N_I & ~CS_N_I;

  // ---------------- Link domain, rising edges: address capture ----------------
  logic [2:0]        rise_cnt_r;
  logic [2:0]        rise_cnt_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;

  // Address and edge count for the rising side of each frame
  always_comb
  begin
    rise_cnt_nxt = rise_cnt_r + 3'h1;
    addr_nxt     = addr_r;
    if (rise_cnt_r < ADDR_EDGES)
      addr_nxt = {addr_r[ADDR_W-2:0], ADDR_I};
  end

  // Edge count restarts with every frame
  always_ff @(posedge IO_CLK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
      rise_cnt_r <= '0;
    else
      rise_cnt_r <= rise_cnt_nxt;
  end

  // The address survives select going high, since the system side may still be reading it
  always_ff @(posedge IO_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      addr_r <= '0;
    else
      addr_r <= addr_nxt;
  end

  // ---------------- Link domain, falling edges: result shift and start ----------------
  logic [2:0]      fall_cnt_r;
  logic [2:0]      fall_cnt_nxt;
  logic            smp_req_r;
  logic            smp_req_nxt;
  logic            start_tgl_r;
  logic            start_tgl_nxt;

  // Falling-edge count picks the outgoing bit and marks sampling and start
  always_comb
  begin
    fall_cnt_nxt  = fall_cnt_r + 3'h1;
    smp_req_nxt   = smp_req_r;
    start_tgl_nxt = start_tgl_r;
    if (fall_cnt_r == SAMPLE_FALL)
      smp_req_nxt = 1'b1;
    if (fall_cnt_r == EDGE_LAST)
    begin
      smp_req_nxt   = 1'b0;
      start_tgl_nxt = ~start_tgl_r;
    end
  end

  // Count and sampling request end with the frame
  always_ff @(negedge IO_CLK_I or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      fall_cnt_r <= '0;
      smp_req_r  <= 1'b0;
    end
    else
    begin
      fall_cnt_r <= fall_cnt_nxt;
      smp_req_r  <= smp_req_nxt;
    end
  end

  // A toggle rather than a pulse, so select rising cannot swallow a start
  always_ff @(negedge IO_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      start_tgl_r <= 1'b0;
    else
      start_tgl_r <= start_tgl_nxt;
  end

  // ---------------- System clock domain ----------------
  sacp_sys_t       r;
  sacp_sys_t       nxt;
  sacp_sar_out_t   sar_st;
  logic            start_ev;
  logic            sar_start;

  // Start toggle edge, accepted only once the select filter has run out
  assign start_ev  = r.st_s2 ^ r.st_s3;
  assign sar_start = start_ev & r.active & ~sar_st.busy;

  // Next state of synchronisers, select filter, sampling and channel
  always_comb
  begin
    nxt        = r;
    nxt.cs_s1  = CS_N_I;
    nxt.cs_s2  = r.cs_s1;
    nxt.st_s1  = start_tgl_r;
    nxt.st_s2  = r.st_s1;
    nxt.st_s3  = r.st_s2;
    nxt.smp_s1 = smp_req_r;
    nxt.smp_s2 = r.smp_s1;
    nxt.smp_s3 = r.smp_s2;
    // Select filter: three quiet cycles before the port answers
    if (r.cs_s2)
    begin
      nxt.filt   = '0;
      nxt.active = 1'b0;
    end
    else if (!r.active)
    begin
      if (r.filt == CS_FILT_LAST)
        nxt.active = 1'b1;
      else
        nxt.filt = r.filt + 2'h1;
    end
    // Hold switch open while the host paces the sampling edges
    nxt.sample = r.smp_s2 & r.active;
    // Selector follows the address once sampling opens and again at start
    if ((r.smp_s2 && !r.smp_s3) || sar_start)
      nxt.mux_sel = sacp_chan_decode(addr_r);
  end

  // System state register
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      r <= '{cs_s1: 1'b1, cs_s2: 1'b1, default: '0};
    else
      r <= nxt;
  end

  // Converter core, timed by the system clock
  sacp_sar u_sar (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .start_i (sar_start),
    .comp_i  (COMP_I),
    .st_o    (sar_st)
  );

  // Outputs. The result and address are read across domains without synchronisers:
  // the host keeps the transfer clock still or select high for 36 cycles while they change.
  assign DOUT_O    = sar_st.result[MSB_IDX - fall_cnt_r];
  assign DOUT_OE_O = r.active;
  assign SAMPLE_O  = r.sample;
  assign MUX_SEL_O = r.mux_sel;
  assign DAC_O     = sar_st.trial;
  assign BUSY_O    = sar_st.busy;

  // ---------------- Checks ----------------
  // Select high takes the driver off the line within one cycle of the synchronised level
  property p_hiz;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    r.cs_s2 |=> !DOUT_OE_O;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while select high");

  // Noise on select must not wake the port during the filter
  property p_filt_quiet;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    $fell(r.cs_s2) |-> (!r.active)[*3];
  endproperty
  a_filt_quiet: assert property (p_filt_quiet) else $error("port answered inside filter");

  // Once the filter has run out the port must answer
  property p_filt_end;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    ($fell(r.cs_s2) ##1 (!r.cs_s2)[*2]) |=> DOUT_OE_O;
  endproperty
  a_filt_end: assert property (p_filt_end) else $error("output not enabled after filter");

  // An accepted start converts the channel whose address is held at that moment
  property p_start;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    sar_start |=> BUSY_O && MUX_SEL_O == sacp_chan_decode($past(addr_r));
  endproperty
  a_start: assert property (p_start) else $error("start did not convert held channel");

  // The hold switch follows the host's sampling window
  property p_sample;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    (r.smp_s2 && r.active) |=> SAMPLE_O;
  endproperty
  a_sample: assert property (p_sample) else $error("sampling request not followed");

  // The eighth falling edge of every group of eight requests a conversion
  property p_eighth;
    @(negedge IO_CLK_I) disable iff (!link_rst_n)
    fall_cnt_r == EDGE_LAST |=> start_tgl_r != $past(start_tgl_r);
  endproperty
  a_eighth: assert property (p_eighth) else $error("no start at eighth falling edge");

  // Every falling edge moves the outgoing bit by one
  property p_shift;
    @(negedge IO_CLK_I) disable iff (!link_rst_n)
    1'b1 |=> fall_cnt_r == 3'($past(fall_cnt_r) + 3'h1);
  endproperty
  a_shift: assert property (p_shift) else $error("result bit did not advance");

  // The first four rising edges shift in the address
  property p_addr;
    @(posedge IO_CLK_I) disable iff (!link_rst_n)
    rise_cnt_r < ADDR_EDGES |=> addr_r == {$past(addr_r[ADDR_W-2:0]), $past(ADDR_I)};
  endproperty
  a_addr: assert property (p_addr) else $error("address bit not captured");

  // The MSB is on the line as soon as the port answers, before any transfer-clock edge
  property p_msb_first;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(DOUT_OE_O) |-> DOUT_O == sar_st.result[MSB_IDX];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("MSB not presented at select");

  // Only twelve selector codes exist: eleven inputs and the self-test voltage
  property p_chan_range;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    MUX_SEL_O <= CH_SELFTEST;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("selector code out of range");

  // The converted channel must not move while the conversion runs
  property p_mux_hold;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    BUSY_O |=> $stable(MUX_SEL_O);
  endproperty
  a_mux_hold: assert property (p_mux_hold) else $error("channel changed during conversion");

  // The previous result stands through a transfer and moves only when a conversion ends
  property p_result_hold;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    $changed(sar_st.result) |-> sar_st.done;
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed outside conversion end");

  // A conversion may only begin while the port answers, never inside the filter
  property p_conv_active;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(BUSY_O) |-> $past(DOUT_OE_O);
  endproperty
  a_conv_active: assert property (p_conv_active) else $error("conversion began while port quiet");

  // The hold switch lets go when the conversion begins
  property p_hold_release;
    @(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(BUSY_O) |-> !SAMPLE_O;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("still sampling during conversion");

  c_start: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) sar_start);
  c_held_sel: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) $fell(BUSY_O) && r.active);
  c_active: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) $rose(r.active));
  c_selftest: cover property (@(posedge MCLK_I) disable iff (!RST_N_I) sar_start && addr_r > CH_LAST_EXT);

endmodule

`default_nettype wire

// *** tb/sacp_host.sv ***
// Behavioural host controller for the serial port of the converter control block.
// Assumes the bench calls its tasks; the transfer clock runs only inside frames.
`default_nettype none

module sacp_host
(
  output logic      cs_n_o,
  output logic      io_clk_o,
  output logic      addr_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  logic last_q;
  logic lvl;

  // Released line shows the inverse of its last driven level, so a missing enable cannot pass
  always @(dout_i or dout_oe_i)
  begin
    if (dout_oe_i)
    begin
      last_q = dout_i;
    end
  end
  assign lvl = dout_oe_i ? dout_i : ~last_q;

  initial
  begin
    cs_n_o   = 1'b1;
    io_clk_o = 1'b0;
    addr_o   = 1'b0;
    last_q   = 1'b0;
  end

  task automatic sel(input logic v);
    cs_n_o = v;
  endtask

  // One 8-clock frame at 64 ns; keep_low leaves select low across the conversion
  task automatic frame(input logic [3:0] a, input bit keep_low, output logic [7:0] rd);
    int i;
    cs_n_o = 1'b0;
    #413;                                         // Ten clocks of setup, off the system clock phase
    for (i = 0; i < 8; i++)
    begin
      addr_o = (i < 4) ? a[3 - i] : 1'b0;        // MSB first on the first four rises
      #32;
      rd[7 - i] = lvl;
      io_clk_o  = 1'b1;
      #32;
      io_clk_o  = 1'b0;
    end
    if (keep_low)
    begin
      #1800;                                      // Clock held low for 45 cycles
    end
    else
    begin
      #40;
      cs_n_o = 1'b1;
      #1800;                                      // Select held high for 45 cycles
    end
  endtask
endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the converter control block with a behavioural host and comparator.
// Assumes the host model drives the link; the comparator answers from a per-channel input code.
`default_nettype none

module testbench
  import sacp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              mclk;
  logic              rst_n;
  logic              io_clk;
  logic              cs_n;
  logic              addr;
  logic              comp;
  logic              dout;
  logic              dout_oe;
  logic              sample;
  logic [ADDR_W-1:0] mux_sel;
  logic [RES_W-1:0]  dac;
  logic              busy;
  int                bad_count;
  int                n_checks;
  int                busy_len;
  int                busy_run;
  int                n_starts;
  int                n_smp;
  logic              busy_q;
  logic              smp_q;
  logic [RES_W-1:0]  dac_first;
  logic [ADDR_W-1:0] mux_seen;
  logic [RES_W-1:0]  prev;

  sacp_top u_sacp_top (.MCLK_I(mclk), .RST_N_I(rst_n), .IO_CLK_I(io_clk), .CS_N_I(cs_n), .ADDR_I(addr),
    .COMP_I(comp), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .SAMPLE_O(sample), .MUX_SEL_O(mux_sel), .DAC_O(dac),
    .BUSY_O(busy));

  sacp_host u_sacp_host (.cs_n_o(cs_n), .io_clk_o(io_clk), .addr_o(addr), .dout_i(dout), .dout_oe_i(dout_oe));

  // Input code of each channel: channel in the top nibble, its inverse below
  function automatic logic [7:0] vin(input logic [3:0] ch);
    return {ch, ~ch};
  endfunction

  // Codes above ten fold onto the self-test input
  function automatic logic [3:0] dec(input logic [3:0] a);
    return (a > 4'hA) ? 4'hB : a;
  endfunction

  // Ideal comparator on the selected channel
  assign comp = (vin(mux_sel) >= dac);

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Conversion monitor: busy length, first trial code, selected channel at sampling
  always @(posedge mclk)
  begin
    busy_q <= busy;
    smp_q  <= sample;
    if (busy === 1'b1)
      busy_len <= busy_len + 1;
    if (busy === 1'b1 && busy_q === 1'b0)
    begin
      dac_first <= dac;
      n_starts  <= n_starts + 1;
    end
    if (busy === 1'b0 && busy_q === 1'b1)
    begin
      busy_run <= busy_len;
      busy_len <= 0;
    end
    if (sample === 1'b1 && smp_q === 1'b0)
    begin
      mux_seen <= mux_sel;
      n_smp    <= n_smp + 1;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Idle state after reset, then a select glitch shorter than the filter
  task automatic t_reset();
    chk("oe", 1'b0, dout_oe);
    chk("busy", 1'b0, busy);
    chk("dac", 8'h00, dac);
    @(negedge mclk);
    u_sacp_host.sel(1'b0);
    @(negedge mclk);
    u_sacp_host.sel(1'b1);
    repeat (10) @(negedge mclk);
    chk("oe glitch", 1'b0, dout_oe);
    chk("starts glitch", 0, n_starts);
    $display("test reset done");
  endtask

  // Every address code; each frame returns the previous result
  task automatic t_chain();
    logic [7:0] rd;
    int         s0;
    int         m0;
    int         i;
    prev = 8'h00;
    for (i = 0; i < 16; i++)
    begin
      @(negedge mclk);
      s0 = n_starts;
      m0 = n_smp;
      u_sacp_host.frame(i[3:0], 1'b0, rd);
      chk("result", prev, rd);
      chk("channel", dec(i[3:0]), mux_seen);
      chk("starts", s0 + 1, n_starts);
      chk("samples", m0 + 1, n_smp);
      chk("busy len", 36, busy_run);
      chk("first trial", 8'h80, dac_first);
      prev = vin(dec(i[3:0]));
    end
    $display("test chain done");
  endtask

  // Select alone shows the MSB, and release puts the line in high impedance
  task automatic t_oe();
    @(negedge mclk);
    u_sacp_host.sel(1'b0);
    repeat (8) @(negedge mclk);
    chk("oe low", 1'b1, dout_oe);
    chk("msb", prev[7], dout);
    u_sacp_host.sel(1'b1);
    repeat (5) @(negedge mclk);
    chk("oe high", 1'b0, dout_oe);
    $display("test oe done");
  endtask

  // Select held low across conversions, counter wraps for the next frame
  task automatic t_cs_low();
    logic [7:0] rd;
    @(negedge mclk);
    u_sacp_host.frame(4'h5, 1'b1, rd);
    chk("held result", prev, rd);
    u_sacp_host.frame(4'h9, 1'b1, rd);
    chk("wrap result", vin(4'h5), rd);
    u_sacp_host.frame(4'h0, 1'b0, rd);
    chk("last result", vin(4'h9), rd);
    chk("busy len", 36, busy_run);
    $display("test cs low done");
  endtask

  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    bad_count = 0;
    n_checks  = 0;
    busy_len  = 0;
    busy_run  = 0;
    n_starts  = 0;
    n_smp     = 0;
    rst_n     = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_chain();
    t_oe();
    t_cs_low();
    end_of_test();
  end
endmodule

`default_nettype wire
